// file: design/aqp_classify.sv
// dirtiness classification with hysteresis and sensitivity shift
`default_nettype none
`include "aqp_regs.svh"
module aqp_classify (
  input wire logic [15:0] dirt, // max minus current resistance
  input wire logic [1:0] sens, // sensitivity select
  input wire logic [63:0] thr, // dirtiness_thresholds g4..g1
  input wire aqp_pkg::aqp_level_t prev, // present measured level
  output aqp_pkg::aqp_level_t level // new measured level
);
  // low sensitivity doubles every threshold, high halves it
  function automatic logic [16:0] shiftThr(input logic [15:0] t, input logic [1:0] s);
    if (s == `AQP_SENS_LOW) return {t, 1'b0};
    else if (s == `AQP_SENS_HIGH) return {2'h0, t[15:1]};
    else return {1'b0, t};
  endfunction

  logic [16:0] g1, g2, g3, g4;
  assign g1 = shiftThr(thr[15:0], sens);
  assign g2 = shiftThr(thr[31:16], sens);
  assign g3 = shiftThr(thr[47:32], sens);
  assign g4 = shiftThr(thr[63:48], sens);

  // rising thresholds g2 and g4, falling g1 and g3, so a level does not chatter
  always_comb begin
    level = prev;
    unique case (prev)
      2'h0: if ({1'b0, dirt} >= g4) level = 2'h2; else if ({1'b0, dirt} >= g2) level = 2'h1;
      2'h1: if ({1'b0, dirt} >= g4) level = 2'h2; else if ({1'b0, dirt} < g1) level = 2'h0;
      default: if ({1'b0, dirt} < g1) level = 2'h0; else if ({1'b0, dirt} < g3) level = 2'h1;
    endcase
  end
endmodule // aqp_classify
`default_nettype wire

// file: design/aqp_monitor.sv
// air quality monitoring controller with wishbone register access
// Summary of operation
// - power-on starts monitoring unless auto entry off or monitoring disabled
// - button starts stand-alone or adds to cooling
// - power, button, ionizer button, off timer end
// - five second hold disables auto entry
// - fifteen second hold disables monitoring
// - two minute stabilisation forces level two
// - sample resistance periodically, high means clean
// - dirtiness is maximum minus current resistance
// - thresholds classify into levels zero to two
// - sensitivity shifts whole threshold set
// - level one or two starts ionizer
// - improvement two to one applied after 60s
// - ionizer stops after ten clean minutes
// - auto fan adds 0, 20, 40 rpm
// - combined operation keeps mode's fan and swing
// - stand-alone ionizing forces auto fan, with level boost
// - stand-alone ionizing forces auto swing
// - stand-alone ionizer stop halts fan, closes louver
// - indicators light for monitoring and ionizer
// - long beep stopping, short beep otherwise (a five or fifteen second hold release gets the long beep unless power or off timer is in the same write)
// - on timer resumes without monitoring, off stops
// - power fail resumes previous monitoring operation
//
// Implementation choices: the register offsets and the Wishbone slave port.
`default_nettype none
`include "aqp_regs.svh"
module aqp_monitor #(
  parameter int unsigned TICK_CYCLES = `AQP_TICK_CYC
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // one-cycle acknowledge
  input wire logic [1:0] restoreMode, // retained mode from backup store
  output logic [1:0] savedMode, // mode to retain over power loss
  output aqp_pkg::aqp_drive_t drive // fan, louver, ionizer, indicators
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic isMon(input aqp_pkg::aqp_mode_t m);
    return (m == aqp_pkg::AQP_ALONE) || (m == aqp_pkg::AQP_COMB);
  endfunction

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [15:0] sensor_q;
  logic [63:0] thr_q;
  logic [7:0] cmd;
  logic wbReq;
  logic wrCfg;
  aqp_pkg::aqp_mode_t mode_q;
  aqp_pkg::aqp_level_t level_q, meas_q, measNew;
  logic ion_q;
  logic [15:0] max_q;
  logic inStab;

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd = (wbReq && wb_we_i && wb_adr_i == `AQP_OFS_CMD && wb_sel_i[0]) ?
               wb_dat_i[7:0] : 8'h0;
  assign wrCfg = wbReq && wb_we_i && wb_adr_i == `AQP_OFS_CFG;

  // answer one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          `AQP_OFS_CFG: wb_dat_o <= cfg_q;
          `AQP_OFS_SENSOR: wb_dat_o <= {16'h0, sensor_q};
          `AQP_OFS_STATUS: wb_dat_o <= {max_q, 8'h0, inStab, ion_q, meas_q,
                                        level_q, mode_q};
          `AQP_OFS_THR_LO: wb_dat_o <= thr_q[31:0];
          `AQP_OFS_THR_HI: wb_dat_o <= thr_q[63:32];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // time base and hold measurement
  // ------------------------------------------------------------
  logic tick;
  logic [9:0] hold_q;
  logic holding_q;
  logic shortPress, holdNoAuto, holdDisable;

  aqp_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(tick)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      holding_q <= 1'b0;
      hold_q <= 10'h0;
    end else if (cmd[`AQP_CMD_MON_DOWN]) begin
      holding_q <= 1'b1;
      hold_q <= 10'h0;
    end else if (cmd[`AQP_CMD_MON_UP]) begin
      holding_q <= 1'b0;
    end else if (holding_q && tick && hold_q != 10'h3ff) begin
      hold_q <= hold_q + 10'h1;
    end
  end

  // hold length is judged only at release
  assign holdDisable = cmd[`AQP_CMD_MON_UP] && holding_q && hold_q >= `AQP_HOLD_DIS_S;
  assign holdNoAuto = cmd[`AQP_CMD_MON_UP] && holding_q && !holdDisable &&
                      hold_q >= `AQP_HOLD_NOAUTO_S;
  assign shortPress = cmd[`AQP_CMD_MON_UP] && holding_q && hold_q < `AQP_HOLD_NOAUTO_S;

  // ------------------------------------------------------------
  // configuration and data registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= `AQP_CFG_RESET;
    end else begin
      if (wrCfg) cfg_q <= mergeLanes(cfg_q, wb_dat_i, wb_sel_i);
      // a hold release outranks a software write of the same bit
      if (holdNoAuto) cfg_q[`AQP_CFG_NOAUTO] <= 1'b1;
      if (holdDisable) cfg_q[`AQP_CFG_MONDIS] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sensor_q <= 16'h0;
      thr_q <= {`AQP_G4_RESET, `AQP_G3_RESET, `AQP_G2_RESET, `AQP_G1_RESET};
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i == `AQP_OFS_SENSOR)
        sensor_q <= 16'(mergeLanes({16'h0, sensor_q}, wb_dat_i, wb_sel_i));
      if (wb_adr_i == `AQP_OFS_THR_LO) thr_q[31:0] <= mergeLanes(thr_q[31:0], wb_dat_i, wb_sel_i);
      if (wb_adr_i == `AQP_OFS_THR_HI)
        thr_q[63:32] <= mergeLanes(thr_q[63:32], wb_dat_i, wb_sel_i);
    end
  end

  // ------------------------------------------------------------
  // power-fail restore
  // ------------------------------------------------------------
  logic [1:0] restSync1_q, restSync2_q;
  logic [1:0] restWait_q;
  logic restore;

  always_ff @(posedge clk) begin
    restSync1_q <= restoreMode;
    restSync2_q <= restSync1_q;
  end

  // wait until the synchroniser has settled before looking at the stored mode
  always_ff @(posedge clk) begin
    if (srst) restWait_q <= 2'h0;
    else if (restWait_q != 2'h3) restWait_q <= restWait_q + 2'h1;
  end
  assign restore = restWait_q == 2'h2;

  // ------------------------------------------------------------
  // operation mode
  // ------------------------------------------------------------
  aqp_pkg::aqp_mode_t modeNext;
  logic beepL, beepS, monStart, monDis;
  logic standIon;

  assign monDis = cfg_q[`AQP_CFG_MONDIS];
  assign standIon = mode_q == aqp_pkg::AQP_ALONE && ion_q;

  always_comb begin
    modeNext = mode_q;
    beepL = 1'b0;
    beepS = 1'b0;
    if (restore) begin
      if (isMon(aqp_pkg::aqp_mode_t'(restSync2_q))) modeNext = aqp_pkg::aqp_mode_t'(restSync2_q);
    end else if (cmd[`AQP_CMD_OFF_TMR]) begin
      modeNext = aqp_pkg::AQP_OFF;
      beepL = mode_q != aqp_pkg::AQP_OFF;
    end else if (cmd[`AQP_CMD_POWER]) begin
      if (mode_q == aqp_pkg::AQP_OFF) begin
        modeNext = (!monDis && !cfg_q[`AQP_CFG_NOAUTO]) ? aqp_pkg::AQP_COMB
                                                        : aqp_pkg::AQP_RUN;
        beepS = 1'b1;
      end else begin
        modeNext = aqp_pkg::AQP_OFF;
        beepL = 1'b1;
      end
    end else if (shortPress && !monDis) begin
      unique case (mode_q)
        aqp_pkg::AQP_OFF: begin
          modeNext = aqp_pkg::AQP_ALONE;
          beepS = 1'b1;
        end
        aqp_pkg::AQP_RUN: begin
          if (cfg_q[`AQP_CFG_COOLONLY]) begin
            modeNext = aqp_pkg::AQP_COMB;
            beepS = 1'b1;
          end
        end
        aqp_pkg::AQP_ALONE: begin
          modeNext = aqp_pkg::AQP_OFF;
          beepL = 1'b1;
        end
        aqp_pkg::AQP_COMB: begin
          modeNext = aqp_pkg::AQP_RUN;
          beepL = 1'b1;
        end
      endcase
    end else if (holdNoAuto || holdDisable) begin
      beepL = 1'b1;
      if (holdDisable && mode_q == aqp_pkg::AQP_ALONE) modeNext = aqp_pkg::AQP_OFF;
      if (holdDisable && mode_q == aqp_pkg::AQP_COMB) modeNext = aqp_pkg::AQP_RUN;
    end else if (cmd[`AQP_CMD_ION]) begin
      if (isMon(mode_q)) begin
        modeNext = (mode_q == aqp_pkg::AQP_COMB) ? aqp_pkg::AQP_RUN : aqp_pkg::AQP_OFF;
        beepL = 1'b1;
      end else begin
        beepS = 1'b1;
      end
    end else if (cmd[`AQP_CMD_ON_TMR]) begin
      if (mode_q == aqp_pkg::AQP_OFF) begin
        modeNext = aqp_pkg::AQP_RUN;
        beepS = 1'b1;
      end
    end else if (cmd[`AQP_CMD_FAN] || cmd[`AQP_CMD_SWING]) begin
      beepS = !standIon && mode_q != aqp_pkg::AQP_OFF;
    end
  end

  assign monStart = isMon(modeNext) && !isMon(mode_q);

  always_ff @(posedge clk) begin
    if (srst) mode_q <= aqp_pkg::AQP_OFF;
    else mode_q <= modeNext;
  end

  // ------------------------------------------------------------
  // gas sensor evaluation
  // ------------------------------------------------------------
  logic [9:0] stab_q, sample_q, improve_q, clean_q;
  logic sampleNow;

  assign inStab = isMon(mode_q) && stab_q != 10'h0;
  assign sampleNow = isMon(mode_q) && !inStab && tick && sample_q == 10'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      stab_q <= 10'h0;
      sample_q <= 10'h0;
    end else if (monStart) begin
      stab_q <= `AQP_STAB_S;
      sample_q <= 10'h0;
    end else if (tick && isMon(mode_q)) begin
      if (stab_q != 10'h0) stab_q <= stab_q - 10'h1;
      else if (sample_q == 10'h0) sample_q <= `AQP_SAMPLE_S - 10'h1;
      else sample_q <= sample_q - 10'h1;
    end
  end

  // the first sample after stabilisation seeds the maximum
  logic haveMax_q;
  always_ff @(posedge clk) begin
    if (srst || monStart) begin
      max_q <= 16'h0;
      haveMax_q <= 1'b0;
    end else if (sampleNow) begin
      haveMax_q <= 1'b1;
      if (!haveMax_q || sensor_q > max_q) max_q <= sensor_q;
    end
  end

  logic [15:0] dirt;
  assign dirt = (haveMax_q && max_q > sensor_q) ? max_q - sensor_q : 16'h0;

  aqp_classify u_class (
    .dirt(dirt),
    .sens(cfg_q[`AQP_CFG_SENS_LSB +: 2]),
    .thr(thr_q),
    .prev(meas_q),
    .level(measNew)
  );

  always_ff @(posedge clk) begin
    if (srst) meas_q <= 2'h2;
    else if (monStart || inStab) meas_q <= 2'h2;
    else if (sampleNow) meas_q <= measNew;
  end

  // ------------------------------------------------------------
  // applied level and ionizer
  // ------------------------------------------------------------
  // any drop from level two waits out the improvement delay
  always_ff @(posedge clk) begin
    if (srst || monStart || !isMon(mode_q)) begin
      level_q <= 2'h2;
      improve_q <= 10'h0;
    end else if (level_q == 2'h2 && meas_q != 2'h2) begin
      if (improve_q >= `AQP_IMPROVE_S) begin
        level_q <= meas_q;
        improve_q <= 10'h0;
      end else if (tick) begin
        improve_q <= improve_q + 10'h1;
      end
    end else begin
      level_q <= meas_q;
      improve_q <= 10'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !isMon(mode_q)) begin
      ion_q <= 1'b0;
      clean_q <= 10'h0;
    end else if (level_q != 2'h0) begin
      ion_q <= 1'b1;
      clean_q <= 10'h0;
    end else if (clean_q >= `AQP_CLEAN_S) begin
      ion_q <= 1'b0;
    end else if (tick) begin
      clean_q <= clean_q + 10'h1;
    end
  end

  // ------------------------------------------------------------
  // drive outputs
  // ------------------------------------------------------------
  logic fanAutoEff;
  assign fanAutoEff = standIon || (mode_q != aqp_pkg::AQP_ALONE && cfg_q[`AQP_CFG_AUTOFAN]);

  always_ff @(posedge clk) begin
    if (srst) begin
      drive <= '0;
      savedMode <= 2'h0;
    end else begin
      savedMode <= mode_q;
      drive.fanRun <= (mode_q == aqp_pkg::AQP_ALONE) ? ion_q : mode_q != aqp_pkg::AQP_OFF;
      drive.louverOpen <= (mode_q == aqp_pkg::AQP_ALONE) ? ion_q
                                                         : mode_q != aqp_pkg::AQP_OFF;
      drive.fanAuto <= fanAutoEff;
      drive.swingAuto <= standIon || (mode_q != aqp_pkg::AQP_ALONE &&
                                      cfg_q[`AQP_CFG_AUTOSWING]);
      if (ion_q && fanAutoEff && level_q == 2'h2) drive.rpmOffset <= `AQP_RPM_LVL2;
      else if (ion_q && fanAutoEff && level_q == 2'h1) drive.rpmOffset <= `AQP_RPM_LVL1;
      else drive.rpmOffset <= 7'h0;
      drive.ionOn <= ion_q;
      drive.monLed <= isMon(mode_q);
      drive.ionLed <= ion_q;
      drive.beepLong <= beepL;
      drive.beepShort <= beepS;
    end
  end
endmodule // aqp_monitor
`default_nettype wire

// file: design/aqp_tick.sv
// one-second time base from the system clock
`default_nettype none
`include "aqp_regs.svh"
module aqp_tick #(
  parameter int unsigned CYCLES = `AQP_TICK_CYC
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  output logic tick // one-cycle pulse per second
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // aqp_tick
`default_nettype wire

// file: pkg/aqp_pkg.sv
// types shared by the air quality monitor files
`default_nettype none
package aqp_pkg;
  // gray along off -> alone -> combined -> running
  typedef enum logic [1:0] {
    AQP_OFF = 2'h0,
    AQP_ALONE = 2'h1,
    AQP_COMB = 2'h3,
    AQP_RUN = 2'h2
  } aqp_mode_t;

  typedef logic [1:0] aqp_level_t;

  typedef struct packed {
    logic fanRun;
    logic fanAuto;
    logic swingAuto;
    logic louverOpen;
    logic [6:0] rpmOffset;
    logic ionOn;
    logic monLed;
    logic ionLed;
    logic beepLong;
    logic beepShort;
  } aqp_drive_t;
endpackage
`default_nettype wire

// file: pkg/aqp_regs.svh
// register map, field positions, reset values and timing constants of the monitor
`ifndef AQP_REGS_SVH
`define AQP_REGS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define AQP_OFS_CMD 8'h00
`define AQP_OFS_CFG 8'h04
`define AQP_OFS_SENSOR 8'h08
`define AQP_OFS_STATUS 8'h0c
`define AQP_OFS_THR_LO 8'h10
`define AQP_OFS_THR_HI 8'h14
// ------------------------------------------------------------
// command bits (write one to issue)
// ------------------------------------------------------------
`define AQP_CMD_POWER 0
`define AQP_CMD_MON_DOWN 1
`define AQP_CMD_MON_UP 2
`define AQP_CMD_ION 3
`define AQP_CMD_ON_TMR 4
`define AQP_CMD_OFF_TMR 5
`define AQP_CMD_FAN 6
`define AQP_CMD_SWING 7
// ------------------------------------------------------------
// configuration fields and reset values
// ------------------------------------------------------------
`define AQP_CFG_SENS_LSB 0
`define AQP_CFG_AUTOFAN 2
`define AQP_CFG_AUTOSWING 3
`define AQP_CFG_COOLONLY 4
`define AQP_CFG_NOAUTO 5
`define AQP_CFG_MONDIS 6
`define AQP_SENS_LOW 2'h0
`define AQP_SENS_STD 2'h1
`define AQP_SENS_HIGH 2'h2
`define AQP_CFG_RESET 32'h0000000d
`define AQP_G1_RESET 16'h0020
`define AQP_G2_RESET 16'h0040
`define AQP_G3_RESET 16'h0080
`define AQP_G4_RESET 16'h0100
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define AQP_CLK_HZ 100000000
`define AQP_TICK_S 1
`define AQP_TICK_CYC (`AQP_CLK_HZ * `AQP_TICK_S)
`define AQP_STAB_S 10'd120
`define AQP_SAMPLE_S 10'd4
`define AQP_IMPROVE_S 10'd60
`define AQP_CLEAN_S 10'd600
`define AQP_HOLD_NOAUTO_S 10'd5
`define AQP_HOLD_DIS_S 10'd15
`define AQP_RPM_LVL1 7'h14
`define AQP_RPM_LVL2 7'h28
`endif

// file: testbench/aqp_backup_model.sv
// backup store model holding the operating mode over a power loss
`default_nettype none
module aqp_backup_model (
  input wire logic clk, // system clock
  input wire logic powerLost, // high while supply is gone
  input wire logic [1:0] savedMode, // mode offered for retention
  output logic [1:0] restoreMode // retained mode
);
  // ------
  // retention
  // ------
  logic [1:0] keptMode_q = 2'h0;
  // frozen during the outage so the zeros of the reset are not kept
  always @(posedge clk) begin
    if (!powerLost) begin
      keptMode_q <= savedMode;
    end
  end
  assign restoreMode = keptMode_q;
endmodule // aqp_backup_model
`default_nettype wire

// file: testbench/aqp_monitor_chk.sv
// port checker for the air quality monitor
`default_nettype none
`include "aqp_regs.svh"
module aqp_monitor_chk #(
  parameter int unsigned TICK_CYCLES = `AQP_TICK_CYC
) (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic [1:0] restoreMode, // retained mode
  input wire logic [1:0] savedMode, // current mode
  input wire aqp_pkg::aqp_drive_t drive // drive bundle
);
  // ------
  // properties
  // ------
  logic cmdWr;
  assign cmdWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && wb_adr_i == `AQP_OFS_CMD && wb_sel_i[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
  off_timer_a: assert property (cmdWr && wb_dat_i[`AQP_CMD_OFF_TMR] |=> ##1
    savedMode == aqp_pkg::AQP_OFF) else $error("off timer left unit running");
  power_stop_a: assert property (cmdWr && wb_dat_i[`AQP_CMD_POWER]
    && savedMode != aqp_pkg::AQP_OFF |=> ##1 savedMode == aqp_pkg::AQP_OFF)
    else $error("power toggle did not stop");
  mon_led_a: assert property (drive.monLed ==
    (savedMode inside {aqp_pkg::AQP_ALONE, aqp_pkg::AQP_COMB}))
    else $error("monitor indicator wrong");
  alone_idle_a: assert property ((savedMode == aqp_pkg::AQP_ALONE && !drive.ionOn)[*3]
    |-> !drive.fanRun && !drive.louverOpen) else $error("fan or louver active without ionizer");
  alone_auto_a: assert property (savedMode == aqp_pkg::AQP_ALONE && drive.ionOn
    |-> drive.fanAuto && drive.swingAuto) else $error("manual fan or swing while ionizing");
  rpm_level_a: assert property (drive.rpmOffset != 7'h0 |-> drive.ionOn && drive.fanAuto
    && drive.rpmOffset inside {`AQP_RPM_LVL1, `AQP_RPM_LVL2}) else $error("bad rpm offset");
  beep_ack_a: assert property (drive.beepLong || drive.beepShort |-> wb_ack_o
    && !(drive.beepLong && drive.beepShort)) else $error("beep without accepted command");
  key_ignored_a: assert property (cmdWr && savedMode == aqp_pkg::AQP_ALONE && drive.ionOn
    && (wb_dat_i[`AQP_CMD_FAN] || wb_dat_i[`AQP_CMD_SWING])
    |=> !drive.beepShort && !drive.beepLong ##1 $stable(savedMode)) else $error("key not ignored");
endmodule // aqp_monitor_chk
bind aqp_monitor aqp_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk(clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .restoreMode(restoreMode), .savedMode(savedMode), .drive(drive));
`default_nettype wire

// file: testbench/aqp_monitor_tb.sv
// self-checking bench for the air quality monitor
`default_nettype none
`include "aqp_regs.svh"
module aqp_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKC = 10;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [1:0] restoreMode;
  logic [1:0] savedMode;
  logic powerLost = 1'b1;
  aqp_pkg::aqp_drive_t drive;
  logic [31:0] rd;
  logic beepL;
  logic beepS;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  aqp_monitor #(.TICK_CYCLES(TICKC)) dut_u (.clk(clk), .srst(srst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .restoreMode(restoreMode), .savedMode(savedMode),
    .drive(drive));
  aqp_backup_model store_u (.clk(clk), .powerLost(powerLost), .savedMode(savedMode),
    .restoreMode(restoreMode));
  // ------
  // tasks
  // ------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request held until the edge that sees ack; answer taken in that cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    check("ack", wbAck, 32'h1);
    rd = wbDatO;
    beepL = drive.beepLong;
    beepS = drive.beepShort;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(negedge clk);
  endtask
  task automatic cmd(input int bitNo);
    xfer(1'b1, `AQP_OFS_CMD, 32'h1 << bitNo);
  endtask
  task automatic status();
    xfer(1'b0, `AQP_OFS_STATUS, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * TICKC) @(negedge clk);
  endtask
  // restore is sampled only after release, so the store stays frozen a while
  task automatic pfReset();
    @(posedge clk);
    powerLost <= 1'b1;
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    powerLost <= 1'b0;
    @(negedge clk);
  endtask
  // ------
  // sequence
  // ------
  initial begin
    pfReset();
    check("mode", savedMode, aqp_pkg::AQP_OFF);
    xfer(1'b0, `AQP_OFS_CFG, 32'h0);
    check("cfg", rd, `AQP_CFG_RESET);
    xfer(1'b0, `AQP_OFS_THR_LO, 32'h0);
    check("thrLo", rd, {`AQP_G2_RESET, `AQP_G1_RESET});
    xfer(1'b0, `AQP_OFS_THR_HI, 32'h0);
    check("thrHi", rd, {`AQP_G4_RESET, `AQP_G3_RESET});
    xfer(1'b1, 8'h40, 32'hffffffff);
    xfer(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    cmd(`AQP_CMD_POWER);
    check("beepS", beepS, 32'h1);
    check("mode", savedMode, aqp_pkg::AQP_COMB);
    check("monLed", drive.monLed, 32'h1);
    cmd(`AQP_CMD_POWER);
    check("beepL", beepL, 32'h1);
    check("mode", savedMode, aqp_pkg::AQP_OFF);
    cmd(`AQP_CMD_MON_DOWN);
    cmd(`AQP_CMD_MON_UP);
    check("mode", savedMode, aqp_pkg::AQP_ALONE);
    xfer(1'b1, `AQP_OFS_SENSOR, 32'h1000);
    ticks(2);
    status();
    check("stab", rd[7], 32'h1);
    check("level", rd[3:2], 32'h2);
    check("ion", drive.ionOn, 32'h1);
    check("ionLed", drive.ionLed, 32'h1);
    check("rpm", drive.rpmOffset, `AQP_RPM_LVL2);
    cmd(`AQP_CMD_FAN);
    check("beepS", beepS, 32'h0);
    cmd(`AQP_CMD_SWING);
    check("beepS", beepS, 32'h0);
    ticks(130);
    status();
    check("meas", rd[5:4], 32'h0);
    check("level", rd[3:2], 32'h2);
    check("max", rd[31:16], 32'h1000);
    ticks(65);
    status();
    check("level", rd[3:2], 32'h0);
    check("ion", drive.ionOn, 32'h1);
    ticks(605);
    check("ion", drive.ionOn, 32'h0);
    check("fan", drive.fanRun, 32'h0);
    check("louver", drive.louverOpen, 32'h0);
    xfer(1'b1, `AQP_OFS_CFG, 32'h0000000e);
    xfer(1'b1, `AQP_OFS_SENSOR, 32'h0fd0);
    ticks(10);
    status();
    check("meas", rd[5:4], 32'h1);
    check("rpm", drive.rpmOffset, `AQP_RPM_LVL1);
    xfer(1'b1, `AQP_OFS_CFG, `AQP_CFG_RESET);
    xfer(1'b1, `AQP_OFS_SENSOR, 32'h0e80);
    ticks(10);
    status();
    check("meas", rd[5:4], 32'h2);
    check("rpm", drive.rpmOffset, `AQP_RPM_LVL2);
    xfer(1'b1, `AQP_OFS_SENSOR, 32'h0fa0);
    ticks(10);
    status();
    check("meas", rd[5:4], 32'h1);
    check("level", rd[3:2], 32'h2);
    ticks(62);
    status();
    check("level", rd[3:2], 32'h1);
    xfer(1'b1, `AQP_OFS_SENSOR, 32'h2000);
    ticks(6);
    status();
    check("max", rd[31:16], 32'h2000);
    cmd(`AQP_CMD_ION);
    check("beepL", beepL, 32'h1);
    check("mode", savedMode, aqp_pkg::AQP_OFF);
    cmd(`AQP_CMD_OFF_TMR);
    check("mode", savedMode, aqp_pkg::AQP_OFF);
    cmd(`AQP_CMD_ON_TMR);
    check("mode", savedMode, aqp_pkg::AQP_RUN);
    cmd(`AQP_CMD_ON_TMR);
    check("mode", savedMode, aqp_pkg::AQP_RUN);
    check("monLed", drive.monLed, 32'h0);
    xfer(1'b1, `AQP_OFS_CFG, 32'h0000001d);
    cmd(`AQP_CMD_MON_DOWN);
    cmd(`AQP_CMD_MON_UP);
    check("mode", savedMode, aqp_pkg::AQP_COMB);
    cmd(`AQP_CMD_POWER);
    cmd(`AQP_CMD_POWER);
    check("mode", savedMode, aqp_pkg::AQP_COMB);
    pfReset();
    check("mode", savedMode, aqp_pkg::AQP_COMB);
    cmd(`AQP_CMD_POWER);
    cmd(`AQP_CMD_MON_DOWN);
    ticks(7);
    cmd(`AQP_CMD_MON_UP);
    check("beepL", beepL, 32'h1);
    xfer(1'b0, `AQP_OFS_CFG, 32'h0);
    check("noAuto", rd[5], 32'h1);
    cmd(`AQP_CMD_POWER);
    check("mode", savedMode, aqp_pkg::AQP_RUN);
    cmd(`AQP_CMD_POWER);
    cmd(`AQP_CMD_MON_DOWN);
    ticks(17);
    cmd(`AQP_CMD_MON_UP);
    xfer(1'b0, `AQP_OFS_CFG, 32'h0);
    check("monDis", rd[6], 32'h1);
    cmd(`AQP_CMD_MON_DOWN);
    cmd(`AQP_CMD_MON_UP);
    check("mode", savedMode, aqp_pkg::AQP_OFF);
    finish_test();
  end
endmodule // aqp_monitor_tb
`default_nettype wire
